// *** rtl/fsb_params.svh ***
// Index map and constants of the field statistics and bin width bank
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH
`define FSB_IDX_W 12
`define FSB_IDX_LUMA_PEAK 12'h0AE
`define FSB_IDX_BLUE_FLOOR 12'h0AF
`define FSB_IDX_BLUE_PEAK 12'h0B0
`define FSB_IDX_RED_FLOOR 12'h0B1
`define FSB_IDX_RED_PEAK 12'h0B2
`define FSB_IDX_STAT_FIRST 12'h0AE
`define FSB_IDX_STAT_LAST 12'h0B2
`define FSB_IDX_TBL_FIRST 12'h100
`define FSB_IDX_TBL_LAST 12'h153
`define FSB_TBL_ENTRIES 84
`define FSB_TBL_OFS_W 7
`define FSB_STAT_COUNT 5
`define FSB_SEL_W 3
`define FSB_BAND_W 6
`define FSB_WIDTH_FRAC 8
`define FSB_RECIP_FRAC 10
`define FSB_RSVD_ZERO 16'h0000
`define FSB_MIN_INIT 16'hFFFF
`define FSB_MAX_INIT 16'h0000
`endif

// *** rtl/fsb_pkg.sv ***
// Types shared by the field statistics and bin width bank
`default_nettype none
package fsb_pkg;
    typedef logic [15:0] fsb_word_t;
    typedef enum logic [2:0] {
        FSB_LUMA_PEAK,
        FSB_BLUE_FLOOR,
        FSB_BLUE_PEAK,
        FSB_RED_FLOOR,
        FSB_RED_PEAK
    } fsb_chan_t;
endpackage
`default_nettype wire

// *** rtl/fsb_bank.sv ***
// Field min/max statistics and interleaved quantizer bin width table
`include "fsb_params.svh"
`default_nettype none
module fsb_bank #(
    parameter int PIX_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [`FSB_IDX_W-1:0] host_index,
    input wire logic [15:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    input wire logic dsp_req,
    input wire logic dsp_we,
    input wire logic [`FSB_IDX_W-1:0] dsp_index,
    input wire logic [15:0] dsp_wdata,
    output logic dsp_ready,
    output logic [31:0] dsp_rdata,
    output logic dsp_rvalid,
    input wire logic field_start,
    input wire logic field_end,
    input wire logic pix_valid,
    input wire logic [PIX_W-1:0] pix_luma,
    input wire logic [PIX_W-1:0] pix_blue,
    input wire logic [PIX_W-1:0] pix_red,
    input wire logic stats_ready_clear,
    output logic stats_ready_flag,
    output logic stats_ready_pin,
    input wire logic [`FSB_BAND_W-1:0] quant_band,
    output logic [15:0] quant_bin_width,
    output logic [15:0] quant_reciprocal_width,
    output logic [7:0] quant_bin_width_int,
    output logic [5:0] quant_reciprocal_width_int
);

    ////////////////////////////////////////////////////////////////////////
    // Port decode

    wire host_stat_hit;
    wire host_tbl_hit;
    wire dsp_stat_hit;
    wire dsp_tbl_hit;
    wire host_wr;
    wire dsp_go;
    wire dsp_wr;
    wire tbl_wr_en;
    wire [`FSB_IDX_W-1:0] tbl_wr_index;
    wire [`FSB_TBL_OFS_W-1:0] tbl_wr_ofs;
    wire [15:0] tbl_wr_data;
    wire [`FSB_IDX_W-1:0] host_tbl_rel;
    wire [`FSB_IDX_W-1:0] dsp_tbl_rel;
    wire [`FSB_IDX_W-1:0] host_stat_rel;
    wire [`FSB_IDX_W-1:0] dsp_stat_rel;
    wire [`FSB_SEL_W-1:0] host_stat_sel;
    wire [`FSB_SEL_W-1:0] dsp_stat_sel;
    wire [`FSB_TBL_OFS_W-1:0] host_tbl_ofs;
    wire [`FSB_TBL_OFS_W-1:0] dsp_tbl_ofs;
    wire [15:0] host_read_word;
    wire [15:0] dsp_read_word;

    assign host_stat_hit = (host_index >= `FSB_IDX_STAT_FIRST)
                        && (host_index <= `FSB_IDX_STAT_LAST);
    assign host_tbl_hit = (host_index >= `FSB_IDX_TBL_FIRST)
                       && (host_index <= `FSB_IDX_TBL_LAST);
    assign dsp_stat_hit = (dsp_index >= `FSB_IDX_STAT_FIRST)
                       && (dsp_index <= `FSB_IDX_STAT_LAST);
    assign dsp_tbl_hit = (dsp_index >= `FSB_IDX_TBL_FIRST)
                      && (dsp_index <= `FSB_IDX_TBL_LAST);

    assign host_tbl_rel = host_index - `FSB_IDX_TBL_FIRST;
    assign dsp_tbl_rel = dsp_index - `FSB_IDX_TBL_FIRST;
    assign host_stat_rel = host_index - `FSB_IDX_STAT_FIRST;
    assign dsp_stat_rel = dsp_index - `FSB_IDX_STAT_FIRST;
    assign host_tbl_ofs = host_tbl_rel[`FSB_TBL_OFS_W-1:0];
    assign dsp_tbl_ofs = dsp_tbl_rel[`FSB_TBL_OFS_W-1:0];
    assign host_stat_sel = host_stat_rel[`FSB_SEL_W-1:0];
    assign dsp_stat_sel = dsp_stat_rel[`FSB_SEL_W-1:0];

    // Host never waits; a DSP write colliding with a host write is held off
    assign host_wr = host_req && host_we && host_tbl_hit;
    assign dsp_go = dsp_req && !(host_req && host_we && dsp_we);
    assign dsp_ready = dsp_go;
    assign dsp_wr = dsp_go && dsp_we && dsp_tbl_hit;

    // Stat indices never reach a write path
    assign tbl_wr_en = host_wr || dsp_wr;
    assign tbl_wr_index = host_wr ? host_index : dsp_index;
    assign tbl_wr_ofs = host_wr ? host_tbl_ofs : dsp_tbl_ofs;
    assign tbl_wr_data = host_wr ? host_wdata : dsp_wdata;

    ////////////////////////////////////////////////////////////////////////
    // Statistics accumulators, one lane per channel

    logic [15:0] stat_q [`FSB_STAT_COUNT];
    logic [15:0] acc_q [`FSB_STAT_COUNT];
    logic [15:0] luma_ext;
    logic [15:0] blue_ext;
    logic [15:0] red_ext;
    wire [16*`FSB_STAT_COUNT-1:0] stat_flat;

    assign luma_ext = 16'(pix_luma);
    assign blue_ext = 16'(pix_blue);
    assign red_ext = 16'(pix_red);

    for (genvar c = 0; c < `FSB_STAT_COUNT; c++) begin : g_chan
        localparam bit IS_FLOOR = (c == int'(fsb_pkg::FSB_BLUE_FLOOR))
                               || (c == int'(fsb_pkg::FSB_RED_FLOOR));
        wire [15:0] sample;
        wire [15:0] init_val;
        wire [15:0] base;
        wire better;
        wire [15:0] acc_d;

        assign sample = (c == int'(fsb_pkg::FSB_LUMA_PEAK)) ? luma_ext
                      : (c <= int'(fsb_pkg::FSB_BLUE_PEAK)) ? blue_ext : red_ext;
        assign init_val = IS_FLOOR ? `FSB_MIN_INIT : `FSB_MAX_INIT;
        assign base = field_start ? init_val : acc_q[c];
        assign better = IS_FLOOR ? (sample < base) : (sample > base);
        assign acc_d = (pix_valid && better) ? sample : base;
        assign stat_flat[16*c +: 16] = stat_q[c];

        // No reset: contents only mean something once a field has closed
        always_ff @(posedge clk) begin
            acc_q[c] <= acc_d;
            if (field_end) begin
                stat_q[c] <= acc_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready flag, set wins over clear

    logic ready_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ready_q <= 1'b0;
        end else if (field_end) begin
            ready_q <= 1'b1;
        end else if (stats_ready_clear) begin
            ready_q <= 1'b0;
        end
    end

    assign stats_ready_flag = ready_q;
    assign stats_ready_pin = ready_q;

    ////////////////////////////////////////////////////////////////////////
    // Quantizer table, interleaved reciprocal/width pairs

    logic [15:0] quant_tbl [`FSB_TBL_ENTRIES];

    // Left unreset so it maps onto plain RAM
    always_ff @(posedge clk) begin
        if (tbl_wr_en) begin
            quant_tbl[tbl_wr_ofs] <= tbl_wr_data;
        end
    end

    wire [`FSB_TBL_OFS_W-1:0] band_recip_ofs;
    wire [`FSB_TBL_OFS_W-1:0] band_width_ofs;

    assign band_recip_ofs = {quant_band, 1'b0};
    assign band_width_ofs = {quant_band, 1'b1};

    logic [15:0] width_q;
    logic [15:0] recip_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            width_q <= 16'h0000;
            recip_q <= 16'h0000;
        end else begin
            width_q <= quant_tbl[band_width_ofs];
            recip_q <= quant_tbl[band_recip_ofs];
        end
    end

    assign quant_bin_width = width_q;
    assign quant_reciprocal_width = recip_q;
    assign quant_bin_width_int = width_q[15:`FSB_WIDTH_FRAC];
    assign quant_reciprocal_width_int = recip_q[15:`FSB_RECIP_FRAC];

    ////////////////////////////////////////////////////////////////////////
    // Read paths, same stat storage for both ports

    assign host_read_word = host_stat_hit ? stat_q[host_stat_sel]
                          : host_tbl_hit ? quant_tbl[host_tbl_ofs] : 16'h0000;
    assign dsp_read_word = dsp_stat_hit ? stat_q[dsp_stat_sel]
                         : dsp_tbl_hit ? quant_tbl[dsp_tbl_ofs] : 16'h0000;

    logic [15:0] host_rd_q;
    logic [15:0] dsp_rd_q;
    logic host_rv_q;
    logic dsp_rv_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            host_rd_q <= 16'h0000;
            dsp_rd_q <= 16'h0000;
            host_rv_q <= 1'b0;
            dsp_rv_q <= 1'b0;
        end else begin
            host_rv_q <= host_req && !host_we;
            dsp_rv_q <= dsp_go && !dsp_we;
            if (host_req && !host_we) begin
                host_rd_q <= host_read_word;
            end
            if (dsp_go && !dsp_we) begin
                dsp_rd_q <= dsp_read_word;
            end
        end
    end

    assign host_rdata = {`FSB_RSVD_ZERO, host_rd_q};
    assign dsp_rdata = {`FSB_RSVD_ZERO, dsp_rd_q};
    assign host_rvalid = host_rv_q;
    assign dsp_rvalid = dsp_rv_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_luma_peak_read: assert property (@(posedge clk) disable iff (!rstn)
        host_req && !host_we && host_index == `FSB_IDX_LUMA_PEAK && !field_end
        |=> host_rvalid && host_rdata[15:0] == stat_q[fsb_pkg::FSB_LUMA_PEAK])
        else $error("luma peak read mismatch");

    chk_blue_floor_read: assert property (@(posedge clk) disable iff (!rstn)
        host_req && !host_we && host_index == `FSB_IDX_BLUE_FLOOR && !field_end
        |=> host_rdata[15:0] == stat_q[fsb_pkg::FSB_BLUE_FLOOR])
        else $error("blue floor read mismatch");

    chk_blue_peak_read: assert property (@(posedge clk) disable iff (!rstn)
        dsp_ready && !dsp_we && dsp_index == `FSB_IDX_BLUE_PEAK && !field_end
        |=> dsp_rvalid && dsp_rdata[15:0] == stat_q[fsb_pkg::FSB_BLUE_PEAK])
        else $error("blue peak read mismatch");

    chk_red_floor_order: assert property (@(posedge clk) disable iff (!rstn)
        field_end && pix_valid
        |=> stat_q[fsb_pkg::FSB_RED_FLOOR] <= $past(red_ext))
        else $error("red floor above sample");

    chk_red_peak_order: assert property (@(posedge clk) disable iff (!rstn)
        field_end && pix_valid
        |=> stat_q[fsb_pkg::FSB_RED_PEAK] >= $past(red_ext))
        else $error("red peak below sample");

    chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
        host_rvalid || dsp_rvalid |-> host_rdata[31:16] == 16'h0000
            && dsp_rdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");

    chk_ports_agree: assert property (@(posedge clk) disable iff (!rstn)
        host_req && !host_we && dsp_ready && !dsp_we && host_index == dsp_index
        |=> host_rdata == dsp_rdata)
        else $error("ports read different values");

    chk_tbl_write: assert property (@(posedge clk) disable iff (!rstn)
        tbl_wr_en |=> quant_tbl[$past(tbl_wr_ofs)] == $past(tbl_wr_data))
        else $error("table write lost");

    chk_host_wins: assert property (@(posedge clk) disable iff (!rstn)
        dsp_req && dsp_we && host_req && host_we |-> !dsp_ready
            && (!host_tbl_hit || tbl_wr_index == host_index))
        else $error("write collision mishandled");

    chk_ready_set: assert property (@(posedge clk) disable iff (!rstn)
        field_end |=> stats_ready_flag && stats_ready_pin)
        else $error("ready flag not set");

    chk_stat_no_write: assert property (@(posedge clk) disable iff (!rstn)
        (host_req && host_we && host_stat_hit || dsp_ready && dsp_we && dsp_stat_hit)
            && !field_end
        |=> $stable(stat_flat))
        else $error("stat index written");

    chk_luma_peak_order: assert property (@(posedge clk) disable iff (!rstn)
        field_end && pix_valid
        |=> stat_q[fsb_pkg::FSB_LUMA_PEAK] >= $past(luma_ext))
        else $error("luma peak below sample");

    chk_blue_floor_order: assert property (@(posedge clk) disable iff (!rstn)
        field_end && pix_valid
        |=> stat_q[fsb_pkg::FSB_BLUE_FLOOR] <= $past(blue_ext))
        else $error("blue floor above sample");

    chk_blue_peak_order: assert property (@(posedge clk) disable iff (!rstn)
        field_end && pix_valid
        |=> stat_q[fsb_pkg::FSB_BLUE_PEAK] >= $past(blue_ext))
        else $error("blue peak below sample");

    chk_host_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
        host_rvalid
        |-> $past(host_req && !host_we))
        else $error("host read valid without read");

    chk_dsp_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
        dsp_ready && !dsp_we
        |=> dsp_rvalid)
        else $error("dsp read valid missing");

    chk_dsp_no_stall: assert property (@(posedge clk) disable iff (!rstn)
        dsp_req && !(host_req && host_we)
        |-> dsp_ready)
        else $error("dsp stalled without collision");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        host_req && !host_we && !host_stat_hit && !host_tbl_hit
        |=> host_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
        stats_ready_clear && !field_end
        |=> !stats_ready_flag)
        else $error("ready flag not cleared");

    chk_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
        !stats_ready_clear && !field_end
        |=> $stable(stats_ready_flag))
        else $error("ready flag changed on its own");

endmodule
`default_nettype wire

// *** test/fsb_dsp_model.sv ***
// Behavioural DSP on the serial-port side of the bank
`default_nettype none
module fsb_dsp_model (
    input wire logic clk,
    output logic req,
    output logic we,
    output logic [11:0] index,
    output logic [15:0] wdata,
    input wire logic ready,
    input wire logic [31:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        req = 1'b0;
        we = 1'b0;
        index = 12'hFFF;
        wdata = 16'hA5A5;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Holds the request until taken or 20 cycles pass, since a host write can stall it
    task automatic access(input logic wr, input logic [11:0] idx, input logic [15:0] d,
                          output logic ok, output logic [31:0] q);
        logic taken;
        int n;
        taken = 1'b0;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= wr;
        index <= idx;
        wdata <= d;
        while (!taken && n < 20) begin
            @(posedge clk);
            taken = ready;
            n++;
        end
        req <= 1'b0;
        // Released index and data lines carry no stale value
        index <= ~idx;
        wdata <= ~d;
        ok = taken;
        q = 32'hDEAD_BEEF;
        if (!wr) begin
            @(posedge clk);
            ok = taken && rvalid;
            q = rdata;
        end
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the statistics and bin width bank
`include "fsb_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, h_req = 1'b0, h_we = 1'b0;
    logic [11:0] h_idx = 12'h000, d_idx;
    logic [15:0] h_wd = 16'h0000, d_wd, pl = 16'h0, pb = 16'h0, pr = 16'h0;
    logic [31:0] h_rd, d_rd, q;
    logic h_rv, d_req, d_we, d_rdy, d_rv, fs = 1'b0, fe = 1'b0, pv = 1'b0, clr = 1'b0;
    logic flag, pin, ok;
    logic [5:0] band = 6'h00;
    logic [15:0] q_w, q_r;
    logic [7:0] q_w_int;
    logic [5:0] q_r_int;
    logic [11:0] si;
    int errors = 0, num_checks = 0;
    always #10 clk = ~clk;
    fsb_bank fsb_bank_i (.clk(clk), .rstn(rstn), .host_req(h_req), .host_we(h_we),
        .host_index(h_idx), .host_wdata(h_wd), .host_rdata(h_rd), .host_rvalid(h_rv),
        .dsp_req(d_req), .dsp_we(d_we), .dsp_index(d_idx), .dsp_wdata(d_wd),
        .dsp_ready(d_rdy), .dsp_rdata(d_rd), .dsp_rvalid(d_rv), .field_start(fs),
        .field_end(fe), .pix_valid(pv), .pix_luma(pl), .pix_blue(pb), .pix_red(pr),
        .stats_ready_clear(clr), .stats_ready_flag(flag), .stats_ready_pin(pin),
        .quant_band(band), .quant_bin_width(q_w), .quant_reciprocal_width(q_r),
        .quant_bin_width_int(q_w_int), .quant_reciprocal_width_int(q_r_int));
    fsb_dsp_model fsb_dsp_model_i (.clk(clk), .req(d_req), .we(d_we), .index(d_idx),
        .wdata(d_wd), .ready(d_rdy), .rdata(d_rd), .rvalid(d_rv));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hwr(input logic [11:0] idx, input logic [15:0] d);
        @(posedge clk);
        h_req <= 1'b1;
        h_we <= 1'b1;
        h_idx <= idx;
        h_wd <= d;
        @(posedge clk);
        h_req <= 1'b0;
        h_wd <= ~d;
    endtask
    task automatic hrd(input logic [11:0] idx, input logic [31:0] exp);
        @(posedge clk);
        h_req <= 1'b1;
        h_we <= 1'b0;
        h_idx <= idx;
        @(posedge clk);
        h_req <= 1'b0;
        #1;
        chk("host_rvalid", 32'h1, {31'h0, h_rv});
        chk($sformatf("host read %h", idx), exp, h_rd);
    endtask
    task automatic pix(input logic s, input logic e, input logic v,
                       input logic [15:0] l, input logic [15:0] b, input logic [15:0] r);
        @(posedge clk);
        fs <= s;
        fe <= e;
        pv <= v;
        pl <= l;
        pb <= b;
        pr <= r;
    endtask
    task automatic look(input logic [5:0] b, input logic [15:0] r, input logic [15:0] w);
        @(posedge clk);
        band <= b;
        repeat (2) @(posedge clk);
        #1;
        chk("bin width", {16'h0, w}, {16'h0, q_w});
        chk("reciprocal", {16'h0, r}, {16'h0, q_r});
        chk("bin width int", {24'h0, w[15:8]}, {24'h0, q_w_int});
        chk("reciprocal int", {26'h0, r[15:10]}, {26'h0, q_r_int});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Expected field stats: luma peak C8, Cb 14..46, Cr 3C..12C
    logic [31:0] stat_exp [5] = '{32'hC8, 32'h14, 32'h46, 32'h3C, 32'h12C};
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("flag after reset", 32'h0, {31'h0, flag});
        chk("rvalid after reset", 32'h0, {31'h0, h_rv});
        chk("rdata after reset", 32'h0, h_rd);
        chk("width after reset", 32'h0, {16'h0, q_w});
        chk("recip after reset", 32'h0, {16'h0, q_r});
        $display("test reset done");
        pix(1'b1, 1'b0, 1'b1, 16'h000A, 16'h0032, 16'h005A);
        pix(1'b0, 1'b0, 1'b1, 16'h00C8, 16'h0014, 16'h012C);
        pix(1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'hFFFF);
        pix(1'b0, 1'b1, 1'b1, 16'h0005, 16'h0046, 16'h003C);
        pix(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000);
        #1;
        chk("ready flag", 32'h1, {31'h0, flag});
        chk("ready pin", 32'h1, {31'h0, pin});
        for (int i = 0; i < 5; i++) begin
            si = `FSB_IDX_STAT_FIRST + 12'(i);
            // Both ports read one index in one cycle
            fork
                hrd(si, stat_exp[i]);
                fsb_dsp_model_i.access(1'b0, si, 16'h0000, ok, q);
            join
            chk("dsp read ok", 32'h1, {31'h0, ok});
            chk("dsp stat", stat_exp[i], q);
            fork
                hwr(si, 16'h5555);
                fsb_dsp_model_i.access(1'b1, si, 16'hAAAA, ok, q);
            join
            chk("dsp stat write ok", 32'h1, {31'h0, ok});
            hrd(si, stat_exp[i]);
        end
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        #1;
        chk("flag cleared", 32'h0, {31'h0, flag});
        @(posedge clk);
        fe <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        fe <= 1'b0;
        clr <= 1'b0;
        #1;
        chk("set beats clear", 32'h1, {31'h0, flag});
        $display("test stats done");
        // Host and DSP write in one cycle; the DSP must wait its turn
        fork
            hwr(`FSB_IDX_TBL_FIRST, 16'h0400);
            fsb_dsp_model_i.access(1'b1, 12'h101, 16'h0280, ok, q);
        join
        chk("dsp write ok", 32'h1, {31'h0, ok});
        hwr(12'h152, 16'hFC00);
        fsb_dsp_model_i.access(1'b1, `FSB_IDX_TBL_LAST, 16'hFF80, ok, q);
        hrd(`FSB_IDX_TBL_FIRST, 32'h0400);
        hrd(12'h101, 32'h0280);
        hrd(`FSB_IDX_TBL_LAST, 32'hFF80);
        hrd(12'h154, 32'h0);
        look(6'd0, 16'h0400, 16'h0280);
        look(6'd41, 16'hFC00, 16'hFF80);
        $display("test table done");
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("flag after second reset", 32'h0, {31'h0, flag});
        chk("width after second reset", 32'h0, {16'h0, q_w});
        chk("recip after second reset", 32'h0, {16'h0, q_r});
        repeat (2) @(posedge clk);
        $display("test second reset done");
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
